/* File: sadc_defines.svh */
// timing counts and field positions for the serial converter port
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH
`define SADC_CLK_PERIOD_NS 10
`define SADC_CONV_TIME_NS 7500
`define SADC_CTRL_BITS 4'h8
`define SADC_TRACK_BIT 4'h5
`define SADC_RES_BITS 4'hc
`define SADC_CTRL_START 8'h01
`define SADC_FIFO_DEPTH 32
`define SADC_RES_WIDTH 12
`endif

/* File: sadc_fifo.sv */
// sample fifo with registered read data
`timescale 1ns/10ps
module sadc_fifo #(
  parameter int W = 12,
  parameter int D = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  // --------------------------------------------------
  // parameter check
  // --------------------------------------------------
  generate
    if (D < 2 || (1 << AW) != D || W < 1)
    begin : g_bad
      $error("sadc_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic out_v;
    logic [W-1:0] out_d;
    logic in_rdy;
  } sadc_fifo_st_t;

  sadc_fifo_st_t s_r, s_nxt;
  logic [W-1:0] mem [D];
  logic push;
  logic load;

  // --------------------------------------------------
  // pointer and output logic
  // --------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    push = in_valid & s_r.in_rdy;
    load = (~s_r.out_v | out_ready) & (s_r.cnt != '0);
    if (push)
      s_nxt.wp = s_r.wp + 1'b1;
    if (load)
    begin
      s_nxt.rp = s_r.rp + 1'b1;
      s_nxt.out_d = mem[s_r.rp];
      s_nxt.out_v = 1'b1;
    end
    else if (out_ready)
      s_nxt.out_v = 1'b0;
    s_nxt.cnt = s_r.cnt + CW'(push) - CW'(load);
    // the output register counts as a slot, so D words in total, not D+1
    s_nxt.in_rdy = ((s_nxt.cnt + CW'(s_nxt.out_v)) < CW'(D));
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // storage array, no reset needed
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[s_r.wp] <= in_data;
  end

  assign in_ready = s_r.in_rdy;
  assign out_data = s_r.out_d;
  assign out_valid = s_r.out_v;
endmodule // sadc_fifo

/* File: sadc_host_model.sv */
// host model: shifts control bytes in and results out
`timescale 1ns/10ps
module sadc_host_model (
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout,
  input wire logic strobe,
  input wire logic ext
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // one shift period; dout taken at the rise
  task automatic tick(input logic d, output logic q);
    din = d;
    #62.5;
    sclk = 1'b1;
    q = dout;
    #62.5;
    sclk = 1'b0;
  endtask
  // one frame; abort lifts cs after four bits
  task automatic xfer(input logic [7:0] b, input int gap, input bit abort,
    output logic [11:0] r);
    logic q;
    int i;
    int n;
    r = 12'h000;
    n = ext ? 13 : 12;
    cs_n = 1'b0;
    #200;
    for (i = 0; i < gap; i++) tick(1'b0, q);
    for (i = 7; i >= (abort ? 4 : 0); i--) tick(b[i], q);
    if (!abort)
    begin
      if (!ext) #100;
      for (i = 0; i < 400 && !ext && strobe !== 1'b1; i++) #10;
      for (i = 0; i < n; i++)
      begin
        tick(1'b0, q);
        if (i >= n - 12) r = {r[10:0], q};
      end
    end
    #200;
    cs_n = 1'b1;
    din = ~din; // released line shows no stale level
  endtask
endmodule // sadc_host_model

/* File: sadc_pkg.sv */
// types shared by the serial converter port
package sadc_pkg;
  typedef enum logic [3:0] {
    SADC_IDLE = 4'b0001,
    SADC_CTRL = 4'b0010,
    SADC_CONV = 4'b0100,
    SADC_READ = 4'b1000
  } sadc_state_t;
endpackage

/* File: sadc_serial_if.sv */
// serial control and readout port of the eight-channel converter
`timescale 1ns/10ps
`include "sadc_defines.svh"

module sadc_serial_if #(
  parameter int CONV_TIME_NS = `SADC_CONV_TIME_NS,
  parameter int FIFO_DEPTH = `SADC_FIFO_DEPTH,
  parameter int RES_W = `SADC_RES_WIDTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // serial link pins
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic din_pin,
  output logic dout_o,
  output logic dout_oe,
  output logic conversion_strobe_o,
  output logic conversion_strobe_oe,
  // mode and shutdown level detectors
  input wire logic ext_clk_mode,
  input wire logic shutdown_level_input_hi,
  input wire logic shutdown_level_input_lo,
  // status
  output logic powered_down,
  output logic comp_internal,
  output logic tracking,
  output logic holding,
  output logic [7:0] ctrl_byte,
  output logic ctrl_byte_valid,
  // conversion results from the analog core
  input wire logic [RES_W-1:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready
);
  localparam int CONV_CYCLES_RAW = CONV_TIME_NS / `SADC_CLK_PERIOD_NS;
  localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;

  // --------------------------------------------------
  // parameter check
  // --------------------------------------------------
  generate
    if (RES_W != 12 || CONV_CYCLES > 65535)
    begin : g_bad
      $error("sadc_serial_if needs a 12-bit result and a 16-bit conversion count");
    end
  endgenerate

  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic cs_s1;
    logic cs_s2;
    logic din_s1;
    logic din_s2;
    sadc_pkg::sadc_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] sreg;
    logic [11:0] res;
    logic [3:0] rcnt;
    logic [15:0] ccnt;
    logic dout;
    logic dout_oe;
    logic strb;
    logic strb_oe;
    logic pdn;
    logic cint;
    logic track;
    logic hold;
    logic [7:0] cbyte;
    logic cvalid;
  } sadc_st_t;

  sadc_st_t s_r, s_nxt;
  logic [RES_W-1:0] fifo_data;
  logic fifo_valid;
  logic pop;
  logic rise;
  logic fall;
  logic csl;

  // --------------------------------------------------
  // sample buffer
  // --------------------------------------------------
  sadc_fifo #(
    .W(RES_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_data(sample_data),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  // --------------------------------------------------
  // next-state logic
  // --------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    pop = 1'b0;
    // two-stage synchronisers; edges seen on the second stage only
    s_nxt.sclk_s1 = sclk_pin;
    s_nxt.sclk_s2 = s_r.sclk_s1;
    s_nxt.sclk_d = s_r.sclk_s2;
    s_nxt.cs_s1 = cs_n_pin;
    s_nxt.cs_s2 = s_r.cs_s1;
    s_nxt.din_s1 = din_pin;
    s_nxt.din_s2 = s_r.din_s1;
    rise = s_r.sclk_s2 & ~s_r.sclk_d;
    fall = ~s_r.sclk_s2 & s_r.sclk_d;
    csl = ~s_r.cs_s2;
    s_nxt.cvalid = 1'b0;
    s_nxt.pdn = shutdown_level_input_lo;
    s_nxt.cint = shutdown_level_input_hi & ~shutdown_level_input_lo;
    s_nxt.dout_oe = csl;
    s_nxt.strb_oe = ext_clk_mode ? csl : 1'b1;
    unique case (s_r.st)
      sadc_pkg::SADC_IDLE:
      begin
        // first one is the start bit
        if (csl && rise && s_r.din_s2)
        begin
          s_nxt.st = sadc_pkg::SADC_CTRL;
          s_nxt.bitcnt = 4'h1;
          s_nxt.sreg = `SADC_CTRL_START;
        end
      end
      sadc_pkg::SADC_CTRL:
      begin
        if (rise && s_r.bitcnt < `SADC_CTRL_BITS)
        begin
          s_nxt.sreg = {s_r.sreg[6:0], s_r.din_s2};
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        end
        if (fall && s_r.bitcnt == `SADC_TRACK_BIT)
          s_nxt.track = 1'b1;
        if (fall && s_r.bitcnt == `SADC_CTRL_BITS)
        begin
          s_nxt.track = 1'b0;
          s_nxt.hold = 1'b1;
          s_nxt.cbyte = s_r.sreg;
          s_nxt.cvalid = 1'b1;
          s_nxt.res = fifo_valid ? fifo_data : 12'h000;
          pop = fifo_valid;
          s_nxt.ccnt = 16'h0000;
          s_nxt.st = sadc_pkg::SADC_CONV;
          s_nxt.strb = ext_clk_mode;
        end
      end
      sadc_pkg::SADC_CONV:
      begin
        if (ext_clk_mode ? fall : (s_r.ccnt == 16'(CONV_CYCLES - 1)))
        begin
          s_nxt.strb = ~ext_clk_mode;
          s_nxt.dout = s_r.res[11];
          s_nxt.res = {s_r.res[10:0], 1'b0};
          s_nxt.rcnt = 4'h1;
          s_nxt.st = sadc_pkg::SADC_READ;
        end
        else
          s_nxt.ccnt = s_r.ccnt + 16'h0001;
      end
      sadc_pkg::SADC_READ:
      begin
        if (fall)
        begin
          if (s_r.rcnt == `SADC_RES_BITS)
          begin
            s_nxt.dout = 1'b0;
            s_nxt.hold = 1'b0;
            s_nxt.st = sadc_pkg::SADC_IDLE;
          end
          else
          begin
            s_nxt.dout = s_r.res[11];
            s_nxt.res = {s_r.res[10:0], 1'b0};
            s_nxt.rcnt = s_r.rcnt + 4'h1;
          end
        end
      end
    endcase
    // deselect aborts; internal conversion may finish on its own
    if (!csl && (ext_clk_mode || s_r.st != sadc_pkg::SADC_CONV))
    begin
      s_nxt.st = sadc_pkg::SADC_IDLE;
      s_nxt.bitcnt = 4'h0;
      s_nxt.track = 1'b0;
      s_nxt.hold = 1'b0;
      s_nxt.dout = 1'b0;
      s_nxt.strb = ~ext_clk_mode;
      pop = 1'b0;
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      s_r <= '0;
      s_r.sclk_s1 <= 1'b0;
      s_r.cs_s1 <= 1'b1;
      s_r.cs_s2 <= 1'b1;
      s_r.st <= sadc_pkg::SADC_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  // outputs straight from the state register
  assign dout_o = s_r.dout;
  assign dout_oe = s_r.dout_oe;
  assign conversion_strobe_o = s_r.strb;
  assign conversion_strobe_oe = s_r.strb_oe;
  assign powered_down = s_r.pdn;
  assign comp_internal = s_r.cint;
  assign tracking = s_r.track;
  assign holding = s_r.hold;
  assign ctrl_byte = s_r.cbyte;
  assign ctrl_byte_valid = s_r.cvalid;
endmodule // sadc_serial_if

/* File: sadc_serial_if_assertions.sv */
// pin-level checks for the serial converter port
`timescale 1ns/10ps
module sadc_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // inputs
  input wire logic cs_n_pin,
  input wire logic ext_clk_mode,
  input wire logic shutdown_level_input_hi,
  input wire logic shutdown_level_input_lo,
  // outputs
  input wire logic dout_oe,
  input wire logic conversion_strobe_o,
  input wire logic conversion_strobe_oe,
  input wire logic powered_down,
  input wire logic comp_internal,
  input wire logic tracking,
  input wire logic holding,
  input wire logic [7:0] ctrl_byte,
  input wire logic ctrl_byte_valid
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_pd; shutdown_level_input_lo |=> powered_down; endproperty
  a_pd: assert property (p_pd) else $error("no power down");
  property p_ci; shutdown_level_input_hi && !shutdown_level_input_lo |=> comp_internal; endproperty
  a_ci: assert property (p_ci) else $error("no internal comp");
  property p_oe; cs_n_pin [*6] |-> !dout_oe; endproperty
  a_oe: assert property (p_oe) else $error("dout driven");
  property p_oe1; (!cs_n_pin) [*6] |-> dout_oe; endproperty
  a_oe1: assert property (p_oe1) else $error("dout not driven");
  property p_so1; (!cs_n_pin && ext_clk_mode) [*6] |-> conversion_strobe_oe; endproperty
  a_so1: assert property (p_so1) else $error("strobe not driven");
  property p_so; (cs_n_pin && ext_clk_mode) [*6] |-> !conversion_strobe_oe; endproperty
  a_so: assert property (p_so) else $error("strobe driven");
  property p_hd; $rose(holding) |-> !tracking && $past(tracking); endproperty
  a_hd: assert property (p_hd) else $error("hold order");
  property p_cv; ctrl_byte_valid |-> holding && ctrl_byte[7]; endproperty
  a_cv: assert property (p_cv) else $error("bad byte");
  property p_sx; ext_clk_mode && $rose(conversion_strobe_o) |->
    conversion_strobe_o [*8] ##[1:8] !conversion_strobe_o; endproperty
  a_sx: assert property (p_sx) else $error("strobe width");
  property p_si; !ext_clk_mode && $fell(conversion_strobe_o) |-> holding; endproperty
  a_si: assert property (p_si) else $error("strobe fall");
endmodule // sadc_chk

bind sadc_serial_if sadc_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .cs_n_pin(cs_n_pin),
  .ext_clk_mode(ext_clk_mode), .shutdown_level_input_hi(shutdown_level_input_hi),
  .shutdown_level_input_lo(shutdown_level_input_lo), .dout_oe(dout_oe),
  .conversion_strobe_o(conversion_strobe_o), .conversion_strobe_oe(conversion_strobe_oe),
  .powered_down(powered_down), .comp_internal(comp_internal), .tracking(tracking),
  .holding(holding), .ctrl_byte(ctrl_byte), .ctrl_byte_valid(ctrl_byte_valid));

/* File: sadc_serial_if_tb_top.sv */
// self-checking bench for the serial converter port
`timescale 1ns/10ps
module sadc_serial_if_tb_top;
  logic sys_clk, nrst, sclk_pin, cs_n_pin, din_pin, ext_clk_mode, sample_valid, sample_ready;
  logic shutdown_level_input_hi, shutdown_level_input_lo, dout_o, dout_oe, tracking, holding;
  logic conversion_strobe_o, conversion_strobe_oe, powered_down, comp_internal, ctrl_byte_valid;
  logic [7:0] ctrl_byte;
  logic [7:0] b;
  logic [11:0] sample_data, v, r;
  logic [11:0] q[$];
  logic [31:0] seed = 32'h0000_0021;
  int errors = 0;
  int checks = 0;
  int k;
  sadc_serial_if #(.CONV_TIME_NS(2000)) u_dut (.sys_clk(sys_clk), .nrst(nrst),
    .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .din_pin(din_pin), .dout_o(dout_o),
    .dout_oe(dout_oe), .conversion_strobe_o(conversion_strobe_o),
    .conversion_strobe_oe(conversion_strobe_oe), .ext_clk_mode(ext_clk_mode),
    .shutdown_level_input_hi(shutdown_level_input_hi),
    .shutdown_level_input_lo(shutdown_level_input_lo), .powered_down(powered_down),
    .comp_internal(comp_internal), .tracking(tracking), .holding(holding),
    .ctrl_byte(ctrl_byte), .ctrl_byte_valid(ctrl_byte_valid), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready));
  sadc_host_model u_host (.sclk(sclk_pin), .cs_n(cs_n_pin), .din(din_pin), .dout(dout_o),
    .strobe(conversion_strobe_o), .ext(ext_clk_mode));
  // xorshift source and expected result
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [11:0] exp_res();
    return (q.size() == 0) ? 12'h000 : q.pop_front();
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #400000;
    errors++;
    end_sim();
  end
  // main sequence
  initial
  begin
    {nrst, sample_valid, shutdown_level_input_lo} = 3'h0;
    {ext_clk_mode, shutdown_level_input_hi, sample_data} = 14'h3000;
    repeat (5) @(posedge sys_clk);
    #1 nrst = 1'b1;
    // shutdown pin low, high, floating
    for (k = 0; k < 3; k++)
    begin
      @(posedge sys_clk);
      #1 {shutdown_level_input_hi, shutdown_level_input_lo} = {k == 1, k == 0};
      repeat (6) @(posedge sys_clk);
      #1 chk(12'(powered_down), 12'(k == 0));
      chk(12'(comp_internal), 12'(k == 1));
    end
    // fill the fifo until it refuses
    forever
    begin
      @(posedge sys_clk);
      #1;
      if (sample_ready !== 1'b1) break;
      v = 12'(rnd());
      {sample_valid, sample_data} = {1'b1, v};
      q.push_back(v);
    end
    sample_valid = 1'b0;
    chk(12'(q.size()), 12'h020);
    // random frames drain it past empty; frame 3 aborts
    for (k = 0; k < 36; k++)
    begin
      @(posedge sys_clk);
      #1 ext_clk_mode = 1'(rnd());
      b = {1'b1, 7'(rnd())};
      u_host.xfer(b, rnd() % 4, k == 3, r);
      repeat (6) @(posedge sys_clk);
      #1 chk(12'(dout_oe), 12'h000);
      chk(12'(conversion_strobe_oe), 12'(!ext_clk_mode));
      if (k != 3)
      begin
        chk(r, exp_res());
        chk(12'(ctrl_byte), 12'(b));
      end
    end
    end_sim();
  end
endmodule // sadc_serial_if_tb_top
